/* File: hw/scan_port.sv */
/*
  Boundary-scan test access port of the memory: controller, instruction,
  bypass, identification and pin ring chain, plus output-driver control.
  Assumes the scan clock, mode and data pins are asynchronous to ref_clk,
  which runs at least four times faster than the scan clock.
*/
// Behaviour
// - sample mode and data on scan-clock rise
// - serial output changes after scan-clock fall
// - capture latches pin levels at rise
// - identification revision and part fields hardwired
// - identification bits 11..1 hold maker code
// - identification bit 0 reads one
// - code 001 selects identification, memory unaffected
// - code 010 samples, chain selected, outputs float
// - code 100 samples, chain selected, no effect
// - code 111 selects single-bit bypass
// - code 000 external test, 109-cell chain
// - identification instruction after reset state
// - cell 108 gates outputs under code 000 only, preset high
// - chain shifts from msb toward lsb
// - instruction applies only in update or reset state
`timescale 1ns/1ps
`default_nettype none
module scan_port #(
  parameter int CHAIN_LEN = scan_port_pkg::BSR_LEN
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scanClk,
  input wire logic modeSel,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOutEn,
  input wire logic [CHAIN_LEN-1:0] pinLevels,
  output logic [CHAIN_LEN-1:0] pinDrive,
  output logic extTestActive,
  output logic outputsEnable
);
  import scan_port_pkg::*;

  // ********************
  // pin synchronisers and scan-clock edges
  // ********************
  logic clkSync, modeSync, dataSync;
  logic clkLast_q;
  pin_sync uClk (.clk(ref_clk), .rst_n(rst_n), .pinIn(scanClk), .pinOut(clkSync));
  pin_sync uMode (.clk(ref_clk), .rst_n(rst_n), .pinIn(modeSel), .pinOut(modeSync));
  pin_sync uData (.clk(ref_clk), .rst_n(rst_n), .pinIn(dataIn), .pinOut(dataSync));

  wire riseEdge = clkSync & ~clkLast_q;
  wire fallEdge = ~clkSync & clkLast_q;

  // ********************
  // pin ring levels
  // ********************
  // two flops per pin; pins are independent and must stand still around capture
  logic [CHAIN_LEN-1:0] ringMeta_q, ringSafe_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ringMeta_q <= '0;
      ringSafe_q <= '0;
    end else begin
      ringMeta_q <= pinLevels;
      ringSafe_q <= ringMeta_q;
    end
  end

  // ********************
  // controller
  // ********************
  tap_state_t state_q, state_d;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: state_d = modeSync ? ST_RESET : ST_IDLE;
      ST_IDLE: state_d = modeSync ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = modeSync ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = modeSync ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_d = modeSync ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_d = modeSync ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_d = modeSync ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_d = modeSync ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_d = modeSync ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = modeSync ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_d = modeSync ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_d = modeSync ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_d = modeSync ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_d = modeSync ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_d = modeSync ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: state_d = modeSync ? ST_SEL_DR : ST_IDLE;
      default: state_d = ST_RESET;
    endcase
  end

  // ********************
  // instruction decode
  // ********************
  logic [IR_LEN-1:0] irShift_q, irCur_q;
  logic [ID_LEN-1:0] idShift_q;
  logic [CHAIN_LEN-1:0] bsrShift_q, bsrHold_q;
  logic bypass_q;

  wire selIdent = (irCur_q == INS_IDENT);
  wire selBypass = (irCur_q == INS_PASS);
  wire selExternal = (irCur_q == INS_EXTERNAL);
  wire selHiz = (irCur_q == INS_SAMPLE_HIZ);
  wire selChain = selExternal | selHiz | (irCur_q == INS_SAMPLE_PRE);
  // reserved codes fall through to bypass so the chain stays intact
  wire selPass = selBypass | ~(selIdent | selChain);

  wire [ID_LEN-1:0] idWord = {ID_REVISION, ID_PART, ID_MAKER, ID_PRESENT};
  wire inShiftIr = (state_q == ST_SHIFT_IR);
  wire inShiftDr = (state_q == ST_SHIFT_DR);
  wire drTail = selIdent ? idShift_q[0] : (selChain ? bsrShift_q[0] : bypass_q);
  wire serialBit = inShiftIr ? irShift_q[0] : drTail;

  // ********************
  // scan-clock rise: state and shift paths
  // ********************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clkLast_q <= 1'b0;
      state_q <= ST_RESET;
    end else begin
      clkLast_q <= clkSync;
      if (riseEdge) state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irShift_q <= '0;
      irCur_q <= INS_IDENT;
    end else if (riseEdge) begin
      if (state_q == ST_RESET) irCur_q <= INS_IDENT;
      else if (state_q == ST_UPD_IR) irCur_q <= irShift_q;
      if (state_q == ST_CAP_IR) irShift_q <= {1'b0, IR_CAPTURE};
      else if (inShiftIr) irShift_q <= {dataSync, irShift_q[IR_LEN-1:1]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      idShift_q <= '0;
      bypass_q <= 1'b0;
      bsrShift_q <= '0;
    end else if (riseEdge) begin
      if (state_q == ST_CAP_DR) begin
        if (selIdent) idShift_q <= idWord;
        if (selPass) bypass_q <= 1'b0;
        if (selChain) bsrShift_q <= ringSafe_q;
      end else if (inShiftDr) begin
        if (selIdent) idShift_q <= {dataSync, idShift_q[ID_LEN-1:1]};
        if (selPass) bypass_q <= dataSync;
        if (selChain) bsrShift_q <= {dataSync, bsrShift_q[CHAIN_LEN-1:1]};
      end
    end
  end

  // cell 108 preset high so the outputs drive after any reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bsrHold_q <= '0;
      bsrHold_q[OE_CELL] <= 1'b1;
    end else if (riseEdge) begin
      if (state_q == ST_RESET) bsrHold_q[OE_CELL] <= 1'b1;
      else if (state_q == ST_UPD_DR && selChain) bsrHold_q <= bsrShift_q;
    end
  end

  // ********************
  // scan-clock fall: serial output
  // ********************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dataOut <= 1'b0;
      dataOutEn <= 1'b0;
    end else if (fallEdge) begin
      dataOut <= serialBit;
      dataOutEn <= inShiftIr | inShiftDr;
    end
  end

  // ********************
  // memory-side controls
  // ********************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pinDrive <= '0;
      extTestActive <= 1'b0;
      outputsEnable <= 1'b1;
    end else begin
      pinDrive <= bsrHold_q;
      extTestActive <= selExternal;
      outputsEnable <= ~selHiz & ~(selExternal & ~bsrHold_q[OE_CELL]);
    end
  end

  // ********************
  // checks
  // ********************
  upd_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(irCur_q) |-> $past(state_q == ST_UPD_IR || state_q == ST_RESET))
    else $error("instruction changed outside update");
  reset_ident_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (riseEdge && state_q == ST_RESET) |=> (irCur_q == INS_IDENT))
    else $error("reset state did not select identification");
  tdo_fall_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(dataOut) |-> $past(fallEdge))
    else $error("serial output moved off a falling edge");
  hiz_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    selHiz |=> !outputsEnable)
    else $error("outputs driven under sample-hiz");
  id_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (riseEdge && state_q == ST_CAP_DR && selIdent) |=> idShift_q[0] && idShift_q == idWord)
    else $error("identification capture wrong");
  chain_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (riseEdge && state_q == ST_CAP_DR && selChain) |=> bsrShift_q == $past(ringSafe_q))
    else $error("chain capture missed pins");
  state_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (riseEdge && state_q == ST_SHIFT_DR && modeSync) |=> state_q == ST_EXIT1_DR)
    else $error("controller step wrong");
  bypass_shift_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (riseEdge && inShiftDr && selBypass) |=> bypass_q == $past(dataSync))
    else $error("bypass did not take data");
  oe_cell_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (selExternal && !bsrHold_q[OE_CELL]) |=> !outputsEnable)
    else $error("cell 108 low did not float outputs");
endmodule
`default_nettype wire

/* File: hw/scan_port_pkg.sv */
/*
  Constants for the boundary-scan test port: instruction codes, register
  sizes, identification word fields and the controller state encoding.
  Assumes nothing beyond a SystemVerilog package-capable tool.
*/
package scan_port_pkg;

  // ********************
  // register sizes
  // ********************
  localparam int IR_LEN = 3;
  localparam int ID_LEN = 32;
  localparam int BSR_LEN = 109;
  localparam int OE_CELL = 108;

  // ********************
  // instruction codes
  // ********************
  localparam logic [2:0] INS_EXTERNAL = 3'h0;
  localparam logic [2:0] INS_IDENT = 3'h1;
  localparam logic [2:0] INS_SAMPLE_HIZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE_PRE = 3'h4;
  localparam logic [2:0] INS_PASS = 3'h7;

  // ********************
  // identification word (values arbitrary)
  // ********************
  localparam logic [2:0] ID_REVISION = 3'h2;
  localparam logic [16:0] ID_PART = 17'h0ABCD;
  localparam logic [10:0] ID_MAKER = 11'h2A5;
  localparam logic ID_PRESENT = 1'b1;
  localparam logic [1:0] IR_CAPTURE = 2'h1;

  // ********************
  // controller states
  // ********************
  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SHIFT_DR = 4'h4, ST_EXIT1_DR = 4'h5, ST_PAUSE_DR = 4'h6, ST_EXIT2_DR = 4'h7,
    ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SHIFT_IR = 4'hB,
    ST_EXIT1_IR = 4'hC, ST_PAUSE_IR = 4'hD, ST_EXIT2_IR = 4'hE, ST_UPD_IR = 4'hF
  } tap_state_t;

endpackage

/* File: hw/pin_sync.sv */
/*
  Two-flop synchroniser for one level from outside the clock domain.
  Assumes the reference clock is much faster than the signal changes.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pinIn,
  output logic pinOut
);
  logic meta_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      pinOut <= 1'b0;
    end else begin
      meta_q <= pinIn;
      pinOut <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: tb/scan_ctrl_model.sv */
/*
  Board-side test controller model: makes the scan clock, mode and data.
  Assumes ref_clk is the bench clock; scan clock stands low between bits.
*/
`timescale 1ns/1ps
`default_nettype none
module scan_ctrl_model (
  input wire logic ref_clk,
  input wire logic dataOut,
  output logic scanClk,
  output logic modeSel,
  output logic dataIn
);
  initial begin
    scanClk = 1'b0;
    modeSel = 1'b1;
    dataIn = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  // mode and data set in the low phase, held across the rise
  task automatic tick(input logic m, input logic d, output logic q);
    modeSel = m;
    dataIn = d;
    half();
    scanClk = 1'b1;
    half();
    q = dataOut;
    scanClk = 1'b0;
  endtask
  task automatic reset_tap();
    logic q;
    repeat (5) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
  // walk idle to shift, shift, then through update back to idle
  task automatic scan(input logic ir, input int n, input logic [108:0] din,
                      output logic [108:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, q);
    if (ir) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, ~dataIn, q);
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
/*
  Self-checking bench for the scan port, one task per scenario.
  Assumes scan_port_pkg and the controller model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scan_port_pkg::*;
  logic ref_clk, rst_n, scanClk, modeSel, dataIn, dataOut, dataOutEn;
  logic extTestActive, outputsEnable;
  logic [108:0] pinLevels, pinDrive, d;
  int bad_count = 0;
  int tests_run = 0;
  int enCycles = 0;
  localparam logic [108:0] PIN_PAT = {1'h1, {27{4'hA}}};
  localparam logic [108:0] LOAD_PAT = {1'h0, {27{4'h3}}};
  scan_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .scanClk(scanClk), .modeSel(modeSel),
    .dataIn(dataIn), .dataOut(dataOut), .dataOutEn(dataOutEn), .pinLevels(pinLevels),
    .pinDrive(pinDrive), .extTestActive(extTestActive), .outputsEnable(outputsEnable));
  scan_ctrl_model ctrl (.ref_clk(ref_clk), .dataOut(dataOut), .scanClk(scanClk),
    .modeSel(modeSel), .dataIn(dataIn));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ref_clk edges seen with the serial output enabled
  always @(posedge ref_clk) begin
    if (dataOutEn) enCycles <= enCycles + 1;
  end
  // ********************
  // helpers
  // ********************
  task automatic chk(input logic [108:0] got, input logic [108:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // only defined codes are ever loaded
  task automatic load_ir(input logic [2:0] code);
    ctrl.scan(1'b1, 3, 109'(code), d);
    chk(109'(d[1:0]), 109'(IR_CAPTURE));
  endtask
  task automatic test_done();
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic test_ident();
    int en0;
    chk(109'({dataOutEn, extTestActive, outputsEnable}), 109'h1);
    ctrl.reset_tap();
    en0 = enCycles;
    ctrl.scan(1'b0, 32, '0, d);
    chk(d, 109'({ID_REVISION, ID_PART, ID_MAKER, 1'b1}));
    // enabled from the fall entering shift to the fall leaving it, 8 ref_clk per bit
    chk(109'(enCycles - en0), 109'(ID_LEN * 8));
    chk(109'(dataOutEn), 109'h0);
  endtask
  task automatic test_sample_preload();
    load_ir(INS_SAMPLE_PRE);
    ctrl.scan(1'b0, 109, LOAD_PAT, d);
    chk(d, PIN_PAT);
    chk(pinDrive, LOAD_PAT);
    chk(109'({extTestActive, outputsEnable}), 109'h1);
  endtask
  task automatic test_sample_hiz();
    load_ir(INS_SAMPLE_HIZ);
    chk(109'(outputsEnable), 109'h0);
    pinLevels = ~PIN_PAT;
    ctrl.scan(1'b0, 109, LOAD_PAT, d);
    chk(d, ~PIN_PAT);
    pinLevels = PIN_PAT;
  endtask
  task automatic test_external();
    load_ir(INS_EXTERNAL);
    chk(109'({extTestActive, outputsEnable}), 109'h2);
    ctrl.scan(1'b0, 109, ~LOAD_PAT, d);
    chk(d, PIN_PAT);
    chk(pinDrive, ~LOAD_PAT);
    chk(109'(outputsEnable), 109'h1);
  endtask
  task automatic test_passthrough();
    load_ir(INS_PASS);
    ctrl.scan(1'b0, 4, 109'hD, d);
    chk(d, 109'hA);
    chk(109'({extTestActive, outputsEnable}), 109'h1);
  endtask
  task automatic test_logic_reset();
    load_ir(INS_SAMPLE_PRE);
    ctrl.scan(1'b0, 109, LOAD_PAT, d);
    ctrl.reset_tap();
    ctrl.scan(1'b0, 32, '0, d);
    chk(109'(d[0]), 109'h1);
    load_ir(INS_EXTERNAL);
    chk(109'({extTestActive, outputsEnable}), 109'h3);
  endtask
  // ********************
  // main sequence and watchdog
  // ********************
  initial begin
    rst_n = 1'b0;
    pinLevels = PIN_PAT;
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    test_ident();
    test_sample_preload();
    test_sample_hiz();
    test_external();
    test_passthrough();
    test_logic_reset();
    test_done();
  end
  // about 600 scan clocks of 320 ns are expected
  initial begin
    #2000000;
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
